// File: bench/tb_top.sv
`timescale 1ns/10ps
// register block bench: wishbone accesses with expected values
module tb_top;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, clamp_i, e;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
  logic [3:0]  wb_sel_i, peaking_o;
  logic        wb_ack_o, wb_err_o, auto_comp_o, conv_range_o;
  logic [8:0]  red_dig_offset_o, grn_dig_offset_o, blu_dig_offset_o;
  logic [9:0]  red_conv_o, grn_conv_o, blu_conv_o;
  logic [2:0]  frontend_corner_code_o;
  logic [13:0] pll_pixel_total_o;
  logic [5:0]  sample_phase_o;
  logic [7:0]  pre_coast_lines_o, post_coast_lines_o;
  int          num_errors, check_count;
  logic [7:0]  dflt [10] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h2E, 8'h03, 8'h20, 8'h00, 8'h04, 8'h04};
  logic [7:0]  patt [10] = '{8'hA5, 8'h3C, 8'h00, 8'hE4, 8'h10, 8'h12, 8'h34, 8'h3F, 8'hFF, 8'h01};
  vaoc_regs vaoc_regs_inst (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .wb_cyc_i               (wb_cyc_i),
    .wb_stb_i               (wb_stb_i),
    .wb_we_i                (wb_we_i),
    .wb_adr_i               (wb_adr_i),
    .wb_dat_i               (wb_dat_i),
    .wb_sel_i               (wb_sel_i),
    .clamp_i                (clamp_i),
    .wb_dat_o               (wb_dat_o),
    .wb_ack_o               (wb_ack_o),
    .wb_err_o               (wb_err_o),
    .auto_comp_o            (auto_comp_o),
    .red_dig_offset_o       (red_dig_offset_o),
    .grn_dig_offset_o       (grn_dig_offset_o),
    .blu_dig_offset_o       (blu_dig_offset_o),
    .red_conv_o             (red_conv_o),
    .grn_conv_o             (grn_conv_o),
    .blu_conv_o             (blu_conv_o),
    .conv_range_o           (conv_range_o),
    .frontend_corner_code_o (frontend_corner_code_o),
    .peaking_o              (peaking_o),
    .pll_pixel_total_o      (pll_pixel_total_o),
    .sample_phase_o         (sample_phase_o),
    .pre_coast_lines_o      (pre_coast_lines_o),
    .post_coast_lines_o     (post_coast_lines_o)
  );
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one classic cycle, held until ack or err is sampled
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hF);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o));
    chk("answer edges", 2, n);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, x}, q);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // 40 MHz clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, clamp_i} <= 5'h10;
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {64'h0, 4'hF};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("total", 14'h0320, pll_pixel_total_o);
    chk("corner", 3'h7, frontend_corner_code_o);
    chk("red conv", 10'h200, red_conv_o);
    for (int i = 0; i < 10; i++) rd(32'h24 + 32'(4 * i), dflt[i]);
    for (int i = 0; i < 10; i++) xfer(1'b1, 32'h24 + 32'(4 * i), patt[i]);
    for (int i = 0; i < 10; i++) rd(32'h24 + 32'(4 * i), patt[i]);
    settle;
    chk("red conv", 10'h295, red_conv_o);
    chk("green conv", 10'h0F2, grn_conv_o);
    chk("blue conv", 10'h003, blu_conv_o);
    chk("red digital", 9'h000, red_dig_offset_o);
    chk("corner", 3'h0, frontend_corner_code_o);
    chk("peaking", 4'h1, peaking_o);
    chk("total", 14'h1234, pll_pixel_total_o);
    chk("phase", 6'h3F, sample_phase_o);
    chk("pre coast", 8'hFF, pre_coast_lines_o);
    chk("post coast", 8'h01, post_coast_lines_o);
    xfer(1'b1, 32'h38, 8'h05);
    settle;
    chk("total", 14'h1234, pll_pixel_total_o);
    xfer(1'b1, 32'h3C, 8'h00);
    settle;
    chk("total", 14'h0500, pll_pixel_total_o);
    xfer(1'b1, 32'h44, 8'h00, 4'hE);
    chk("err", 0, e);
    rd(32'h44, 8'hFF);
    chk("pre coast kept", 8'hFF, pre_coast_lines_o);
    xfer(1'b1, 32'h4C, 8'h01);
    settle;
    chk("comp", 1, auto_comp_o);
    chk("red digital", 9'h025, red_dig_offset_o);
    chk("green digital", 9'h1BC, grn_dig_offset_o);
    chk("blue digital", 9'h180, blu_dig_offset_o);
    xfer(1'b1, 32'h24, 8'hFF);
    xfer(1'b1, 32'h30, 8'h01);
    settle;
    chk("red digital", 9'h07F, red_dig_offset_o);
    chk("range", 1, conv_range_o);
    chk("red conv", 10'h3FC, red_conv_o);
    xfer(1'b1, 32'h4C, 8'h02);
    xfer(1'b1, 32'h24, 8'h40);
    settle;
    chk("red conv held", 10'h3FC, red_conv_o);
    chk("red digital off", 9'h000, red_dig_offset_o);
    clamp_i <= 1'b1;
    repeat (2) settle;
    clamp_i <= 1'b0;
    chk("red conv clamp", 10'h100, red_conv_o);
    xfer(1'b0, 32'h50, 8'h00);
    chk("err", 1, e);
    xfer(1'b1, 32'h20, 8'h55);
    chk("err", 1, e);
    xfer(1'b0, 32'h25, 8'h00);
    chk("err", 1, e);
    give_verdict;
  end
endmodule // tb_top
bind vaoc_regs vaoc_regs_monitor vaoc_regs_monitor_inst (
  .clk_i                  (clk_i),
  .rst_i                  (rst_i),
  .wb_cyc_i               (wb_cyc_i),
  .wb_stb_i               (wb_stb_i),
  .wb_we_i                (wb_we_i),
  .wb_adr_i               (wb_adr_i),
  .wb_dat_i               (wb_dat_i),
  .wb_sel_i               (wb_sel_i),
  .wb_ack_o               (wb_ack_o),
  .wb_err_o               (wb_err_o),
  .conv_range_o           (conv_range_o),
  .frontend_corner_code_o (frontend_corner_code_o),
  .peaking_o              (peaking_o),
  .pll_pixel_total_o      (pll_pixel_total_o),
  .sample_phase_o         (sample_phase_o),
  .pre_coast_lines_o      (pre_coast_lines_o),
  .post_coast_lines_o     (post_coast_lines_o)
);

// File: bench/vaoc_regs_monitor.sv
`timescale 1ns/10ps
// protocol and field update checks at the register block ports
module vaoc_regs_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire        conv_range_o,
  input wire [2:0]  frontend_corner_code_o,
  input wire [3:0]  peaking_o,
  input wire [13:0] pll_pixel_total_o,
  input wire [5:0]  sample_phase_o,
  input wire [7:0]  pre_coast_lines_o,
  input wire [7:0]  post_coast_lines_o
);
  // accepted write, seen at its ack edge
  wire wr_done = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no answer one cycle after request");
  a_ack_single: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("answer longer than one cycle");
  a_range_update: assert property (wr_done && wb_adr_i == 32'h30
    |=> conv_range_o == $past(wb_dat_i[0])) else $error("range bit not applied");
  a_corner_update: assert property (wr_done && wb_adr_i == 32'h34
    |=> frontend_corner_code_o == $past(wb_dat_i[3:1])) else $error("corner not applied");
  a_peak_update: assert property (wr_done && wb_adr_i == 32'h34
    |=> peaking_o == $past(wb_dat_i[7:4])) else $error("peaking not applied");
  a_total_hold: assert property ($changed(pll_pixel_total_o) && !$past(rst_i)
    |-> wr_done && wb_adr_i == 32'h3C) else $error("total moved without low write");
  a_phase_update: assert property (wr_done && wb_adr_i == 32'h40
    |=> sample_phase_o == $past(wb_dat_i[5:0])) else $error("phase not applied");
  a_precoast_update: assert property (wr_done && wb_adr_i == 32'h44
    |=> pre_coast_lines_o == $past(wb_dat_i[7:0])) else $error("pre coast not applied");
  a_postcoast_update: assert property (wr_done && wb_adr_i == 32'h48
    |=> post_coast_lines_o == $past(wb_dat_i[7:0])) else $error("post coast not applied");
  // main scenarios reached
  cover property (wr_done && wb_adr_i == 32'h3C);
  cover property (wr_done && wb_adr_i == 32'h4C);
  cover property (wb_err_o);
endmodule // vaoc_regs_monitor

// File: rtl/vaoc_chan_offset.v
`timescale 1ns/10ps
// one channel: digital offset and ten-bit converter setting with clamp-timed update
module vaoc_chan_offset (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [7:0]        offset_i,
  input  wire [1:0]        low_bits_i,
  input  wire              auto_comp_i,
  input  wire              load_i,
  output reg  signed [8:0] digital_offset_o,
  output reg  [9:0]        conv_setting_o
);
  `include "vaoc_defines.vh"
  wire [9:0] next_conv = {offset_i, low_bits_i};
  wire signed [8:0] next_dig = $signed({1'b0, offset_i}) - $signed({1'b0, `VAOC_DIG_MID});

  // digital offset follows register while compensation runs
  always @(posedge clk_i) begin
    if (rst_i) begin
      digital_offset_o <= 9'h000;
      conv_setting_o   <= {`VAOC_RST_OFS, 2'b00};
    end else begin
      if (auto_comp_i)
        digital_offset_o <= next_dig;
      else
        digital_offset_o <= 9'h000;
      if (load_i)
        conv_setting_o <= next_conv;
    end
  end
endmodule // vaoc_chan_offset

// File: rtl/vaoc_regs.v
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
// offset, bandwidth and pll configuration registers on classic wishbone
module vaoc_regs (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        clamp_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  output reg         auto_comp_o,
  output reg  [8:0]  red_dig_offset_o,
  output reg  [8:0]  grn_dig_offset_o,
  output reg  [8:0]  blu_dig_offset_o,
  output reg  [9:0]  red_conv_o,
  output reg  [9:0]  grn_conv_o,
  output reg  [9:0]  blu_conv_o,
  output reg         conv_range_o,
  output reg  [2:0]  frontend_corner_code_o,
  output reg  [3:0]  peaking_o,
  output reg  [13:0] pll_pixel_total_o,
  output reg  [5:0]  sample_phase_o,
  output reg  [7:0]  pre_coast_lines_o,
  output reg  [7:0]  post_coast_lines_o
);
  `include "vaoc_defines.vh"

  reg  [7:0] red_channel_offset;
  reg  [7:0] green_channel_offset;
  reg  [7:0] blue_channel_offset;
  reg  [7:0] offset_converter_config;
  reg  [7:0] frontend_bandwidth_peaking;
  reg  [7:0] line_pixel_total_high;
  reg  [7:0] line_pixel_total_low;
  reg  [7:0] sample_phase_select;
  reg  [7:0] coast_lines_before_vsync;
  reg  [7:0] coast_lines_after_vsync;
  reg  [7:0] control;
  reg        clamp_s1;
  reg        clamp_s2;
  reg        clamp_d;
  reg        conv_pending;
  reg  [7:0] next_rdata;
  reg        hit;

  wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [7:0] idx     = wb_adr_i[9:2];
  wire       aligned = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[31:10] == 22'h000000);
  wire       wr      = req & wb_we_i & hit & wb_sel_i[0];
  wire       clamp_sel  = control[`VAOC_CTL_CLAMP_BIT];
  wire       clamp_rise = clamp_s2 & ~clamp_d;
  // converters take new values at clamp edge when clamp selected, else at once
  wire       conv_load  = clamp_sel ? (clamp_rise & conv_pending) : 1'b1;
  wire [8:0] red_dig;
  wire [8:0] grn_dig;
  wire [8:0] blu_dig;
  wire [9:0] red_cv;
  wire [9:0] grn_cv;
  wire [9:0] blu_cv;

  // one write strobe per register, from the decoded index
  wire       wr_red  = wr & (idx == `VAOC_IDX_RED_OFS);
  wire       wr_grn  = wr & (idx == `VAOC_IDX_GRN_OFS);
  wire       wr_blu  = wr & (idx == `VAOC_IDX_BLU_OFS);
  wire       wr_cfg  = wr & (idx == `VAOC_IDX_OFS_CFG);
  wire       wr_bwp  = wr & (idx == `VAOC_IDX_BW_PEAK);
  wire       wr_hi   = wr & (idx == `VAOC_IDX_TOT_HI);
  wire       wr_lo   = wr & (idx == `VAOC_IDX_TOT_LO);
  wire       wr_phs  = wr & (idx == `VAOC_IDX_PHASE);
  wire       wr_pre  = wr & (idx == `VAOC_IDX_PRE_CST);
  wire       wr_post = wr & (idx == `VAOC_IDX_POST_CST);
  wire       wr_ctl  = wr & (idx == `VAOC_IDX_CONTROL);
  // any write that changes a converter input
  wire       wr_conv = wr_red | wr_grn | wr_blu | wr_cfg;

  // output reset values taken apart from the register defaults
  localparam [15:0] RST_TOTAL = {`VAOC_RST_TOT_HI, `VAOC_RST_TOT_LO};
  localparam [7:0]  RST_BWP   = `VAOC_RST_BW_PEAK;
  localparam [7:0]  RST_PHS   = `VAOC_RST_PHASE;
  localparam [7:0]  RST_CFG   = `VAOC_RST_OFS_CFG;
  localparam [7:0]  RST_CTL   = `VAOC_RST_CONTROL;

  // address decode and read mux
  always @* begin
    hit = aligned;
    next_rdata = 8'h00;
    case (idx)
      `VAOC_IDX_RED_OFS:  next_rdata = red_channel_offset;
      `VAOC_IDX_GRN_OFS:  next_rdata = green_channel_offset;
      `VAOC_IDX_BLU_OFS:  next_rdata = blue_channel_offset;
      `VAOC_IDX_OFS_CFG:  next_rdata = offset_converter_config;
      `VAOC_IDX_BW_PEAK:  next_rdata = frontend_bandwidth_peaking;
      `VAOC_IDX_TOT_HI:   next_rdata = line_pixel_total_high;
      `VAOC_IDX_TOT_LO:   next_rdata = line_pixel_total_low;
      `VAOC_IDX_PHASE:    next_rdata = sample_phase_select;
      `VAOC_IDX_PRE_CST:  next_rdata = coast_lines_before_vsync;
      `VAOC_IDX_POST_CST: next_rdata = coast_lines_after_vsync;
      `VAOC_IDX_CONTROL:  next_rdata = control;
      default:            hit = 1'b0;
    endcase
  end

  // bus answer: registered ack or err one cycle after the request, held one cycle, then drop
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      if (req & hit & ~wb_we_i)
        wb_dat_o <= {24'h000000, next_rdata};
    end
  end

  // red channel offset, midpoint after reset
  always @(posedge clk_i) begin
    if (rst_i)
      red_channel_offset <= `VAOC_RST_OFS;
    else if (wr_red)
      red_channel_offset <= wb_dat_i[7:0];
  end

  // green channel offset, midpoint after reset
  always @(posedge clk_i) begin
    if (rst_i)
      green_channel_offset <= `VAOC_RST_OFS;
    else if (wr_grn)
      green_channel_offset <= wb_dat_i[7:0];
  end

  // blue channel offset, midpoint after reset
  always @(posedge clk_i) begin
    if (rst_i)
      blue_channel_offset <= `VAOC_RST_OFS;
    else if (wr_blu)
      blue_channel_offset <= wb_dat_i[7:0];
  end

  // converter range and low bits
  always @(posedge clk_i) begin
    if (rst_i)
      offset_converter_config <= `VAOC_RST_OFS_CFG;
    else if (wr_cfg)
      offset_converter_config <= wb_dat_i[7:0];
  end

  // front-end corner and peaking
  always @(posedge clk_i) begin
    if (rst_i)
      frontend_bandwidth_peaking <= `VAOC_RST_BW_PEAK;
    else if (wr_bwp)
      frontend_bandwidth_peaking <= wb_dat_i[7:0];
  end

  // pixel total high bits, held until the low byte is written
  always @(posedge clk_i) begin
    if (rst_i)
      line_pixel_total_high <= `VAOC_RST_TOT_HI;
    else if (wr_hi)
      line_pixel_total_high <= wb_dat_i[7:0];
  end

  // pixel total low byte
  always @(posedge clk_i) begin
    if (rst_i)
      line_pixel_total_low <= `VAOC_RST_TOT_LO;
    else if (wr_lo)
      line_pixel_total_low <= wb_dat_i[7:0];
  end

  // sampling phase
  always @(posedge clk_i) begin
    if (rst_i)
      sample_phase_select <= `VAOC_RST_PHASE;
    else if (wr_phs)
      sample_phase_select <= wb_dat_i[7:0];
  end

  // lines coasted before vertical sync
  always @(posedge clk_i) begin
    if (rst_i)
      coast_lines_before_vsync <= `VAOC_RST_CST;
    else if (wr_pre)
      coast_lines_before_vsync <= wb_dat_i[7:0];
  end

  // lines coasted after vertical sync
  always @(posedge clk_i) begin
    if (rst_i)
      coast_lines_after_vsync <= `VAOC_RST_CST;
    else if (wr_post)
      coast_lines_after_vsync <= wb_dat_i[7:0];
  end

  // compensation enable and clamp select, upper bits read as zero
  always @(posedge clk_i) begin
    if (rst_i)
      control <= `VAOC_RST_CONTROL;
    else if (wr_ctl)
      control <= {6'h00, wb_dat_i[1:0]};
  end

  // clamp pin synchroniser, edge detect and pending converter update
  always @(posedge clk_i) begin
    if (rst_i) begin
      clamp_s1     <= 1'b0;
      clamp_s2     <= 1'b0;
      clamp_d      <= 1'b0;
      conv_pending <= 1'b0;
    end else begin
      clamp_s1 <= clamp_i;
      clamp_s2 <= clamp_s1;
      clamp_d  <= clamp_s2;
      // a new write in the edge cycle keeps the request alive
      if (wr_conv)
        conv_pending <= 1'b1;
      else if (clamp_rise)
        conv_pending <= 1'b0;
    end
  end

  vaoc_chan_offset u_red (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .offset_i         (red_channel_offset),
    .low_bits_i       (offset_converter_config[3:2]),
    .auto_comp_i      (control[`VAOC_CTL_AUTO_BLACK_LEVEL_COMP_BIT]),
    .load_i           (conv_load),
    .digital_offset_o (red_dig),
    .conv_setting_o   (red_cv)
  );
  vaoc_chan_offset u_grn (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .offset_i         (green_channel_offset),
    .low_bits_i       (offset_converter_config[5:4]),
    .auto_comp_i      (control[`VAOC_CTL_AUTO_BLACK_LEVEL_COMP_BIT]),
    .load_i           (conv_load),
    .digital_offset_o (grn_dig),
    .conv_setting_o   (grn_cv)
  );
  vaoc_chan_offset u_blu (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .offset_i         (blue_channel_offset),
    .low_bits_i       (offset_converter_config[7:6]),
    .auto_comp_i      (control[`VAOC_CTL_AUTO_BLACK_LEVEL_COMP_BIT]),
    .load_i           (conv_load),
    .digital_offset_o (blu_dig),
    .conv_setting_o   (blu_cv)
  );

  // compensation flag and per-channel offsets toward the converters
  always @(posedge clk_i) begin
    if (rst_i) begin
      auto_comp_o      <= RST_CTL[`VAOC_CTL_AUTO_BLACK_LEVEL_COMP_BIT];
      red_dig_offset_o <= 9'h000;
      grn_dig_offset_o <= 9'h000;
      blu_dig_offset_o <= 9'h000;
      red_conv_o       <= {`VAOC_RST_OFS, 2'b00};
      grn_conv_o       <= {`VAOC_RST_OFS, 2'b00};
      blu_conv_o       <= {`VAOC_RST_OFS, 2'b00};
      conv_range_o     <= RST_CFG[0];
    end else begin
      auto_comp_o      <= control[`VAOC_CTL_AUTO_BLACK_LEVEL_COMP_BIT];
      red_dig_offset_o <= red_dig;
      grn_dig_offset_o <= grn_dig;
      blu_dig_offset_o <= blu_dig;
      red_conv_o       <= red_cv;
      grn_conv_o       <= grn_cv;
      blu_conv_o       <= blu_cv;
      conv_range_o     <= offset_converter_config[0];
    end
  end

  // front-end corner and peaking fields
  always @(posedge clk_i) begin
    if (rst_i) begin
      frontend_corner_code_o <= RST_BWP[3:1];
      peaking_o              <= RST_BWP[7:4];
    end else begin
      frontend_corner_code_o <= frontend_bandwidth_peaking[3:1];
      peaking_o              <= frontend_bandwidth_peaking[7:4];
    end
  end

  // pll fields: phase and coast counts follow their registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_phase_o     <= RST_PHS[5:0];
      pre_coast_lines_o  <= `VAOC_RST_CST;
      post_coast_lines_o <= `VAOC_RST_CST;
    end else begin
      sample_phase_o     <= sample_phase_select[5:0];
      pre_coast_lines_o  <= coast_lines_before_vsync;
      post_coast_lines_o <= coast_lines_after_vsync;
    end
  end

  // pixel total reaches the pll only on a low byte write, high bits from storage
  always @(posedge clk_i) begin
    if (rst_i)
      pll_pixel_total_o <= RST_TOTAL[13:0];
    else if (wr_lo)
      pll_pixel_total_o <= {line_pixel_total_high[5:0], wb_dat_i[7:0]};
  end
endmodule // vaoc_regs

// File: shared/vaoc_defines.vh
`ifndef VAOC_DEFINES_VH
`define VAOC_DEFINES_VH
`define VAOC_IDX_RED_OFS   8'h09
`define VAOC_IDX_GRN_OFS   8'h0A
`define VAOC_IDX_BLU_OFS   8'h0B
`define VAOC_IDX_OFS_CFG   8'h0C
`define VAOC_IDX_BW_PEAK   8'h0D
`define VAOC_IDX_TOT_HI    8'h0E
`define VAOC_IDX_TOT_LO    8'h0F
`define VAOC_IDX_PHASE     8'h10
`define VAOC_IDX_PRE_CST   8'h11
`define VAOC_IDX_POST_CST  8'h12
`define VAOC_IDX_CONTROL   8'h13
`define VAOC_RST_OFS       8'h80
`define VAOC_RST_OFS_CFG   8'h00
`define VAOC_RST_BW_PEAK   8'h2E
`define VAOC_RST_TOT_HI    8'h03
`define VAOC_RST_TOT_LO    8'h20
`define VAOC_RST_PHASE     8'h00
`define VAOC_RST_CST       8'h04
`define VAOC_RST_CONTROL   8'h00
`define VAOC_DIG_MID       8'h80
`define VAOC_CTL_AUTO_BLACK_LEVEL_COMP_BIT  0
`define VAOC_CTL_CLAMP_BIT 1
`endif
